// ---- hdl/ust_regs.svh ----
// constants for the upstream transmit opportunity scheduler
// assumes inclusion by the package and every design file that needs it
`ifndef UST_REGS_SVH
`define UST_REGS_SVH
`define UST_SID_W 14
`define UST_SFID_W 32
`define UST_LEN_W 14
`define UST_MS_W 32
`define UST_DEF_W 10
`define UST_IDX_W 4
`define UST_REQMS_W 8
`define UST_N_SID 4
// broadcast sid and the well-known multicast request/data range
`define UST_SID_BCAST 14'h3FFF
`define UST_SID_WK_LO 14'h3FF1
`define UST_SID_WK_HI 14'h3FFE
`endif

// ---- hdl/ust_pkg.sv ----
// types shared by the scheduler and its helpers
// assumes ust_regs.svh is on the include path
`default_nettype none
`include "ust_regs.svh"
package ust_pkg;
   // map information element kinds seen by the modem
   typedef enum logic [3:0] {
      UST_IE_REQ, UST_IE_REQDATA, UST_IE_IMAINT, UST_IE_SMAINT,
      UST_IE_SGRANT, UST_IE_LGRANT, UST_IE_ASGRANT, UST_IE_ALGRANT,
      UST_IE_AUGS, UST_IE_DACK, UST_IE_NULL
   } ust_ie_kind_type;
   typedef enum logic [1:0] {
      UST_TX_GRANT, UST_TX_UREQ, UST_TX_CREQ, UST_TX_CDATA
   } ust_tx_kind_type;
   typedef struct packed {
      logic valid;
      ust_ie_kind_type kind;
      logic [`UST_SID_W-1:0] sid;
      logic [`UST_LEN_W-1:0] len;
      logic [`UST_MS_W-1:0] start;
   } ust_ie_type;
   typedef struct packed {
      logic [`UST_SFID_W-1:0] sfid;
      logic [`UST_SID_W-1:0] sid;
      logic admitted;
   } ust_flow_type;
   typedef struct packed {
      logic valid;
      logic [`UST_IDX_W-1:0] idx;
      logic [`UST_DEF_W-1:0] defer;
      logic data;
   } ust_new_type;
   typedef struct packed {
      logic valid;
      logic [`UST_IDX_W-1:0] idx;
      logic ok;
   } ust_ack_type;
   typedef struct packed {
      logic valid;
      ust_tx_kind_type kind;
      logic [`UST_IDX_W-1:0] idx;
      logic [`UST_SID_W-1:0] sid;
      logic [`UST_SFID_W-1:0] sfid;
      logic [`UST_MS_W-1:0] start;
   } ust_tx_type;
endpackage
`default_nettype wire

// ---- hdl/ust_txop.sv ----
// transmit opportunity count and start spacing for one map element
// assumes a sid hit flag from the lookup; purely combinational
`default_nettype none
`include "ust_regs.svh"
module ust_txop (
   // element under test
   input wire ust_pkg::ust_ie_kind_type i_kind,
   input wire logic [`UST_SID_W-1:0] i_sid,
   input wire logic [`UST_LEN_W-1:0] i_len,
   input wire logic i_hit,
   // request burst size in mini-slots
   input wire logic [`UST_REQMS_W-1:0] i_req_ms,
   // result
   output logic [`UST_LEN_W-1:0] o_cnt,
   output logic [`UST_LEN_W-1:0] o_spc
);
   import ust_pkg::*;
   logic [`UST_LEN_W-1:0] req_spc;

   // a zero burst size would divide by zero, so treat it as one slot
   assign req_spc = (i_req_ms == '0) ? `UST_LEN_W'(1) :
                    `UST_LEN_W'(i_req_ms);

   // count starts per kind and sid class
   always_comb begin
      o_spc = `UST_LEN_W'(1);
      o_cnt = '0;
      case (i_kind)
         UST_IE_REQ: begin
            if (i_hit) begin
               o_cnt = `UST_LEN_W'(1);
            end else begin
               o_spc = req_spc;
               o_cnt = i_len / req_spc;
            end
         end
         UST_IE_REQDATA: begin
            if (i_sid >= `UST_SID_WK_LO && i_sid <= `UST_SID_WK_HI) begin
               // low nibble is the start spacing
               o_spc = {10'h000, i_sid[3:0]};
               o_cnt = i_len / o_spc;
            end else if (i_sid != `UST_SID_BCAST) begin
               // other multicast: space by the request burst
               o_spc = req_spc;
               o_cnt = i_len / req_spc;
            end
         end
         UST_IE_IMAINT: o_cnt = `UST_LEN_W'(1);
         UST_IE_SMAINT, UST_IE_SGRANT, UST_IE_LGRANT, UST_IE_ASGRANT,
         UST_IE_ALGRANT, UST_IE_AUGS: o_cnt = `UST_LEN_W'(1);
         default: o_cnt = '0;
      endcase
   end
endmodule
`default_nettype wire

// ---- hdl/ust_sid_lookup.sv ----
// finds which local flow owns a sid; lowest index wins on a tie
// assumes flows not yet admitted carry no valid sid
`default_nettype none
`include "ust_regs.svh"
module ust_sid_lookup #(
   parameter int N_SID = `UST_N_SID
) (
   // sid to find and flow table
   input wire logic [`UST_SID_W-1:0] i_sid,
   input wire ust_pkg::ust_flow_type [N_SID-1:0] i_flow,
   // result
   output logic o_hit,
   output logic [`UST_IDX_W-1:0] o_idx
);
   import ust_pkg::*;
   logic [N_SID-1:0] match;

   // only admitted flows hold a sid
   for (genvar g = 0; g < N_SID; g++) begin : g_cmp
      assign match[g] = i_flow[g].admitted && i_flow[g].sid == i_sid;
   end

   // priority pick
   always_comb begin
      o_hit = 1'b0;
      o_idx = '0;
      for (int i = N_SID - 1; i >= 0; i--) begin
         if (match[i]) begin
            o_hit = 1'b1;
            o_idx = `UST_IDX_W'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/ust_sched.sv ----
// upstream transmit opportunity scheduler for a cable modem
// assumes map elements arrive one per cycle in time order, a pulse at
// each map start, and random defer counts from the back-off logic
`default_nettype none
`include "ust_regs.svh"

// Notes on behaviour
// - every mini-slot where a burst may begin is an opportunity.
// - a request region yields length over request burst size starts.
// - request/data under sid 3FF4 allows a start every fourth slot.
// - a 24 slot request/data region gives 4, 3, 2 starts for 3FF6/8/C.
// - broadcast initial maintenance is one start at its first slot.
// - grants, maintenance and unicast requests are one dedicated start.
// - a lost map while awaiting a data ack counts the data delivered.
// - own grants first, then unicast requests, then contention.
// - at most one bandwidth request outstanding per service id.
// - no contention use for a service id with a request pending.
// - a configured policy may lift the ordering and the limits.
// - flows carry a 32-bit flow id and, when admitted, a 14-bit sid.
// - deferral counts only request or request/data opportunities.
// - a unicast request or grant ends deferral and is used instead.
module ust_sched #(
   parameter int N_SID = `UST_N_SID
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // map stream
   input wire ust_pkg::ust_ie_type i_ie,
   input wire logic i_map_start,
   input wire logic i_map_lost,
   input wire logic [`UST_REQMS_W-1:0] i_req_ms,
   // flows, new work and acknowledges
   input wire ust_pkg::ust_flow_type [N_SID-1:0] i_flow,
   input wire ust_pkg::ust_new_type i_new,
   input wire ust_pkg::ust_ack_type i_ack,
   input wire logic i_policy,
   // decisions and status
   output ust_pkg::ust_tx_type o_tx,
   output logic [`UST_LEN_W-1:0] o_txop,
   output logic o_delivered,
   output logic [N_SID-1:0] o_pending
);
   import ust_pkg::*;

   typedef struct packed {
      logic want;
      logic data;
      logic [`UST_DEF_W-1:0] defer;
      logic pending;
      logic await;
      logic owned;
   } ust_sid_st_type;

   typedef struct packed {
      ust_sid_st_type [N_SID-1:0] sid;
      ust_tx_type tx;
      logic [`UST_LEN_W-1:0] txop;
      logic deliv;
   } ust_state_type;

   ust_state_type st_r;
   ust_state_type st_nxt;
   logic hit;
   logic [`UST_IDX_W-1:0] hidx;
   logic [`UST_LEN_W-1:0] cnt;
   logic [`UST_LEN_W-1:0] spc;
   logic won;
   logic elig;
   logic [23:0] prod;

   // dedicated transfer kinds addressed to one modem
   function automatic logic is_grant(input ust_ie_kind_type k);
      is_grant = k == UST_IE_SGRANT || k == UST_IE_LGRANT ||
                 k == UST_IE_ASGRANT || k == UST_IE_ALGRANT ||
                 k == UST_IE_AUGS;
   endfunction

   function automatic logic is_cont(input ust_ie_kind_type k);
      is_cont = k == UST_IE_REQ || k == UST_IE_REQDATA;
   endfunction

   // sid ownership over the flow table
   ust_sid_lookup #(.N_SID(N_SID)) u_lookup (
      .i_sid(i_ie.sid),
      .i_flow(i_flow),
      .o_hit(hit),
      .o_idx(hidx)
   );

   // opportunity count and spacing of the current element
   ust_txop u_txop (
      .i_kind(i_ie.kind),
      .i_sid(i_ie.sid),
      .i_len(i_ie.len),
      .i_hit(hit),
      .i_req_ms(i_req_ms),
      .o_cnt(cnt),
      .o_spc(spc)
   );

   // next state; clears come first so a same-cycle set wins
   always_comb begin
      st_nxt = st_r;
      st_nxt.tx = '0;
      st_nxt.deliv = 1'b0;
      won = 1'b0;
      elig = 1'b0;
      prod = '0;
      if (i_map_start) begin
         for (int i = 0; i < N_SID; i++) begin
            st_nxt.sid[i].owned = 1'b0;
         end
      end
      // collision detection only; a miss hands retry to back-off logic
      if (i_ack.valid) begin
         st_nxt.sid[i_ack.idx].await = 1'b0;
         if (i_ack.ok) begin
            st_nxt.sid[i_ack.idx].pending = 1'b0;
         end else begin
            st_nxt.sid[i_ack.idx].want = 1'b0;
         end
      end
      // no resend after a damaged map, avoiding duplicates
      if (i_map_lost) begin
         for (int i = 0; i < N_SID; i++) begin
            if (st_r.sid[i].await) begin
               st_nxt.sid[i].await = 1'b0;
               st_nxt.deliv = 1'b1;
            end
         end
      end
      if (i_ie.valid) begin
         st_nxt.txop = cnt;
         if (hit && is_grant(i_ie.kind)) begin
            // own grant: used first, deferral abandoned
            st_nxt.tx.valid = 1'b1;
            st_nxt.tx.kind = UST_TX_GRANT;
            st_nxt.tx.idx = hidx;
            st_nxt.tx.sid = i_ie.sid;
            st_nxt.tx.sfid = i_flow[hidx].sfid;
            st_nxt.tx.start = i_ie.start;
            st_nxt.sid[hidx].pending = 1'b0;
            st_nxt.sid[hidx].want = 1'b0;
            st_nxt.sid[hidx].owned = 1'b1;
         end else if (hit && i_ie.kind == UST_IE_REQ) begin
            st_nxt.sid[hidx].owned = 1'b1;
            if (st_r.sid[hidx].want &&
                (!st_r.sid[hidx].pending || i_policy)) begin
               st_nxt.tx.valid = 1'b1;
               st_nxt.tx.kind = UST_TX_UREQ;
               st_nxt.tx.idx = hidx;
               st_nxt.tx.sid = i_ie.sid;
               st_nxt.tx.sfid = i_flow[hidx].sfid;
               st_nxt.tx.start = i_ie.start;
               st_nxt.sid[hidx].pending = 1'b1;
               st_nxt.sid[hidx].want = 1'b0;
            end
         end else if (!hit && is_cont(i_ie.kind) && cnt != '0) begin
            // one contention burst per element; a loser keeps its count
            for (int i = 0; i < N_SID; i++) begin
               elig = st_r.sid[i].want && !st_r.sid[i].await &&
                      (!st_r.sid[i].pending || i_policy) &&
                      // a map start frees its own first element already
                      (!(st_r.sid[i].owned && !i_map_start) ||
                       i_policy) &&
                      (i_ie.kind == UST_IE_REQ || st_r.sid[i].data);
               if (elig && {4'h0, st_r.sid[i].defer} >= cnt) begin
                  st_nxt.sid[i].defer = st_r.sid[i].defer -
                                        cnt[`UST_DEF_W-1:0];
               end else if (elig && !won) begin
                  won = 1'b1;
                  prod = {14'h0000, st_r.sid[i].defer} *
                         {10'h000, spc};
                  st_nxt.tx.valid = 1'b1;
                  st_nxt.tx.kind = (i_ie.kind == UST_IE_REQ) ?
                                   UST_TX_CREQ : UST_TX_CDATA;
                  st_nxt.tx.idx = `UST_IDX_W'(i);
                  st_nxt.tx.sid = i_flow[i].sid;
                  st_nxt.tx.sfid = i_flow[i].sfid;
                  st_nxt.tx.start = i_ie.start +
                                    {18'h0_0000, prod[13:0]};
                  st_nxt.sid[i].defer = '0;
                  st_nxt.sid[i].want = 1'b0;
                  if (i_ie.kind == UST_IE_REQ) begin
                     st_nxt.sid[i].pending = 1'b1;
                  end else begin
                     st_nxt.sid[i].await = 1'b1;
                  end
               end
            end
         end
      end
      // new contention entry from the back-off logic
      if (i_new.valid) begin
         st_nxt.sid[i_new.idx].want = 1'b1;
         st_nxt.sid[i_new.idx].data = i_new.data;
         st_nxt.sid[i_new.idx].defer = i_new.defer;
      end
   end

   // single state register
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign o_tx = st_r.tx;
   assign o_txop = st_r.txop;
   assign o_delivered = st_r.deliv;
   for (genvar g = 0; g < N_SID; g++) begin : g_pend
      assign o_pending[g] = st_r.sid[g].pending;
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   chk_grant_first: assert property (
      i_ie.valid && hit && is_grant(i_ie.kind)
      |=> o_tx.valid && o_tx.kind == UST_TX_GRANT && o_txop == 14'h0001)
      else $error("own grant not taken as one dedicated start");
   chk_imaint_one: assert property (
      i_ie.valid && i_ie.kind == UST_IE_IMAINT && !hit
      |=> o_txop == 14'h0001)
      else $error("initial maintenance not a single start");
   chk_wk_quarter: assert property (
      i_ie.valid && i_ie.kind == UST_IE_REQDATA &&
      i_ie.sid == 14'h3FF4 && i_ie.len == 14'h0018 |=> o_txop == 14'h0006)
      else $error("sid 3ff4 region count wrong");
   chk_wk_counts: assert property (
      i_ie.valid && i_ie.kind == UST_IE_REQDATA && i_ie.len == 14'h0018 &&
      (i_ie.sid == 14'h3FF6 || i_ie.sid == 14'h3FF8 || i_ie.sid == 14'h3FFC)
      |=> o_txop == ((($past(i_ie.sid) == 14'h3FF6)) ? 14'h0004 :
                     ($past(i_ie.sid) == 14'h3FF8) ? 14'h0003 : 14'h0002))
      else $error("well-known sid region count wrong");
   chk_req_count: assert property (
      i_ie.valid && i_ie.kind == UST_IE_REQ && !hit &&
      i_ie.len == 14'h000C && i_req_ms == 8'h02 |=> o_txop == 14'h0006)
      else $error("request region count wrong");
   for (genvar g = 0; g < N_SID; g++) begin : g_chk
      chk_lost_map: assert property (
         i_map_lost && st_r.sid[g].await &&
         !(i_ie.valid && is_cont(i_ie.kind))
         |=> o_delivered && !st_r.sid[g].await)
         else $error("lost map did not retire awaited data");
      chk_one_request: assert property (
         o_tx.valid && o_tx.idx == g && !$past(i_policy) &&
         (o_tx.kind == UST_TX_UREQ || o_tx.kind == UST_TX_CREQ)
         |-> !$past(st_r.sid[g].pending))
         else $error("second request while one is outstanding");
      chk_abandon: assert property (
         i_ie.valid && hit && hidx == g && is_grant(i_ie.kind) &&
         !(i_new.valid && i_new.idx == g) |=> !st_r.sid[g].want [*1])
         else $error("deferral kept after an explicit grant");
      chk_defer_hold: assert property (
         !(i_ie.valid && is_cont(i_ie.kind)) && !i_new.valid
         |=> $stable(st_r.sid[g].defer))
         else $error("defer changed outside contention");
   end

   cov_grant: cover property (o_tx.valid && o_tx.kind == UST_TX_GRANT);
   cov_ureq: cover property (o_tx.valid && o_tx.kind == UST_TX_UREQ);
   cov_cont: cover property (o_tx.valid && o_tx.kind == UST_TX_CDATA);
   cov_lost: cover property (o_delivered);
endmodule
`default_nettype wire

// ---- verif/ust_cmts_model.sv ----
// head-end map issuer model: hands the modem one map element per call
// assumes callers start just after a rising clock edge
`default_nettype none
module ust_cmts_model (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // map stream toward the modem
   output ust_pkg::ust_ie_type o_ie,
   output logic o_map_start,
   output logic o_map_lost
);
   timeunit 1ns;
   timeprecision 1ps;
   import ust_pkg::*;

   // quiet stream before the first map
   initial begin
      o_ie = '0;
      o_map_start = 1'b0;
      o_map_lost = 1'b0;
   end

   // one element for one cycle; sid, length and start are inverted once released so
   // a stale element can never pass for a fresh one
   task automatic send(input ust_ie_kind_type k, input logic [13:0] sid,
      input logic [13:0] len, input logic [31:0] st, input logic first);
      // an edge passes first, so a release is never overwritten at once
      @(posedge i_mclk);
      #1;
      o_ie = '{1'b1, k, sid, len, st};
      o_map_start = first;
      @(posedge i_mclk);
      #1;
      o_ie.valid = 1'b0;
      o_ie.sid = ~sid;
      o_ie.len = ~len;
      o_ie.start = ~st;
      o_map_start = 1'b0;
   endtask

   // a map that failed its check reaches the modem only as this pulse
   task automatic lose();
      o_map_lost = 1'b1;
      @(posedge i_mclk);
      #1;
      o_map_lost = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- verif/test_ust_sched.sv ----
// self-checking bench for the upstream opportunity scheduler
// assumes the map model drives elements; the bench drives work and acks
`default_nettype none
module test_ust_sched;
   timeunit 1ns;
   timeprecision 1ps;
   import ust_pkg::*;
   localparam int NS = 4;
   localparam logic [13:0] BC = 14'h3fff;
   logic i_mclk = 1'b0;
   logic i_reset_n = 1'b0;
   ust_ie_type ie;
   logic map_start, map_lost;
   logic [7:0] req_ms = 8'h02;
   ust_flow_type [NS-1:0] flow;
   ust_new_type nw = '0;
   ust_ack_type ack = '0;
   logic policy = 1'b0;
   ust_tx_type tx;
   logic [13:0] txop;
   logic delivered;
   logic [NS-1:0] pending;
   int fail_count = 0;
   int num_checks = 0;
   int k;
   logic [31:0] st, ln;
   ust_ie_kind_type gk [6] = '{UST_IE_SMAINT, UST_IE_SGRANT, UST_IE_LGRANT,
      UST_IE_ASGRANT, UST_IE_ALGRANT, UST_IE_AUGS};
   logic [13:0] wk [4] = '{14'h3ff4, 14'h3ff6, 14'h3ff8, 14'h3ffc};
   // starts in a 24 slot region for each of the sids above
   logic [31:0] wkn [4] = '{32'h0000_0006, 32'h0000_0004,
      32'h0000_0003, 32'h0000_0002};

   // free-running 125 MHz clock
   always #4 i_mclk = ~i_mclk;

   ust_sched #(.N_SID(NS)) uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .i_ie(ie), .i_map_start(map_start), .i_map_lost(map_lost),
      .i_req_ms(req_ms), .i_flow(flow), .i_new(nw), .i_ack(ack),
      .i_policy(policy), .o_tx(tx), .o_txop(txop),
      .o_delivered(delivered), .o_pending(pending));

   ust_cmts_model u_cmts (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
      .o_ie(ie), .o_map_start(map_start), .o_map_lost(map_lost));

   // expected opportunities of a request region; zero size counts as one
   function automatic logic [31:0] req_cnt(input logic [31:0] len,
      input logic [7:0] ms);
      return len / ((ms == 8'h00) ? 32'h0000_0001 : {24'h0, ms});
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // decision pulse seen one cycle after its element
   task automatic chk_tx(input logic v, input ust_tx_kind_type kd,
      input int ix, input logic [31:0] s);
      chk("tx valid", {31'h0, v}, {31'h0, tx.valid});
      if (v) begin
         chk("tx kind", {30'h0, kd}, {30'h0, tx.kind});
         chk("tx idx", 32'(ix), {28'h0, tx.idx});
         chk("tx start", s, tx.start);
         chk("tx sid", {18'h0, flow[ix].sid}, {18'h0, tx.sid});
         chk("tx sfid", flow[ix].sfid, tx.sfid);
      end
   endtask

   // new contention work for one flow; one-cycle pulse
   task automatic want(input int ix, input int dfr, input logic d);
      nw = '{1'b1, 4'(ix), 10'(dfr), d};
      @(posedge i_mclk);
      #1;
      nw.valid = 1'b0;
   endtask

   // ok low reports a collision
   task automatic acked(input int ix, input logic ok = 1'b1);
      ack = '{1'b1, 4'(ix), ok};
      @(posedge i_mclk);
      #1;
      ack.valid = 1'b0;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // a hang would otherwise never reach the verdict
   initial begin
      #400000;
      fail_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'hce98_356f));
      for (k = 0; k < NS; k++)
         flow[k] = '{$urandom, 14'h0010 + 14'(k), 1'b1};
      repeat (10) @(posedge i_mclk);
      chk("pending in reset", 32'h0, {28'h0, pending});
      chk("txop in reset", 32'h0, {18'h0, txop});
      #1 i_reset_n = 1'b1;
      // request regions: corners then random burst sizes
      for (k = 0; k < 10; k++) begin
         req_ms = (k == 0) ? 8'h01 : (k == 1) ? 8'h02 : (k == 2) ? 8'h00 :
            8'($urandom_range(1, 8));
         ln = (k < 3) ? 32'h0000_000c : $urandom_range(1, 200);
         u_cmts.send(UST_IE_REQ, BC, ln[13:0], $urandom, 1'b0);
         chk("req txop", req_cnt(ln, req_ms), {18'h0, txop});
         chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      end
      // well-known multicast request/data, 24 slots
      for (k = 0; k < 4; k++) begin
         u_cmts.send(UST_IE_REQDATA, wk[k], 14'h0018, $urandom, 1'b0);
         chk("wk txop", wkn[k], {18'h0, txop});
      end
      // the count stands across an idle cycle
      @(posedge i_mclk);
      #1;
      chk("wk txop holds", 32'h0000_0002, {18'h0, txop});
      u_cmts.send(UST_IE_REQDATA, 14'h3ff4, 14'h0018, 32'h0, 1'b0);
      chk("wk 3ff4", 32'h0000_0006, {18'h0, txop});
      u_cmts.send(UST_IE_IMAINT, BC, 14'($urandom_range(2, 900)), 0, 1'b0);
      chk("imaint txop", 32'h0000_0001, {18'h0, txop});
      // every dedicated kind is one start; data grants go to the flow
      for (k = 0; k < 6; k++) begin
         st = $urandom;
         u_cmts.send(gk[k], flow[2].sid, 14'h0020, st, 1'b1);
         chk("grant txop", 32'h0000_0001, {18'h0, txop});
         chk_tx(k != 0, UST_TX_GRANT, 2, st);
      end
      // unicast request to an idle flow is refused
      u_cmts.send(UST_IE_REQ, flow[1].sid, 14'h0004, 0, 1'b1);
      chk("ureq txop", 32'h0000_0001, {18'h0, txop});
      chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      // defer three of six starts, then a request stays outstanding
      req_ms = 8'h02;
      want(0, 3, 1'b0);
      u_cmts.send(UST_IE_REQ, BC, 14'h000c, 32'h0000_0100, 1'b1);
      chk_tx(1'b1, UST_TX_CREQ, 0, 32'h0000_0106);
      chk("pending set", 32'h1, {28'h0, pending});
      want(0, 0, 1'b0);
      u_cmts.send(UST_IE_REQ, BC, 14'h000c, 32'h0000_0200, 1'b0);
      chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      u_cmts.send(UST_IE_REQ, flow[0].sid, 14'h0002, 32'h0000_0300, 1'b0);
      chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      policy = 1'b1;
      u_cmts.send(UST_IE_REQ, flow[0].sid, 14'h0002, 32'h0000_0400, 1'b0);
      chk_tx(1'b1, UST_TX_UREQ, 0, 32'h0000_0400);
      policy = 1'b0;
      acked(0);
      chk("pending clear", 32'h0, {28'h0, pending});
      // only eligible contention starts count down the deferral
      want(1, 8, 1'b0);
      u_cmts.send(UST_IE_REQ, BC, 14'h000c, 32'h0000_0500, 1'b1);
      chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      u_cmts.send(UST_IE_IMAINT, BC, 14'h0030, 32'h0000_0600, 1'b0);
      u_cmts.send(UST_IE_REQDATA, 14'h3ff4, 14'h0018, 32'h0000_0700, 1'b0);
      chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      u_cmts.send(UST_IE_SGRANT, flow[2].sid, 14'h0008, 32'h0000_0800, 1'b0);
      chk_tx(1'b1, UST_TX_GRANT, 2, 32'h0000_0800);
      req_ms = 8'h01;
      u_cmts.send(UST_IE_REQ, BC, 14'h0004, 32'h0000_0900, 1'b0);
      chk_tx(1'b1, UST_TX_CREQ, 1, 32'h0000_0902);
      acked(1);
      // an explicit unicast request ends a long deferral
      want(3, 500, 1'b0);
      u_cmts.send(UST_IE_REQ, BC, 14'h000c, 32'h0000_0a00, 1'b1);
      u_cmts.send(UST_IE_REQ, flow[3].sid, 14'h0001, 32'h0000_0b00, 1'b0);
      chk_tx(1'b1, UST_TX_UREQ, 3, 32'h0000_0b00);
      acked(3);
      // contention data, then its map is lost
      want(2, 0, 1'b1);
      u_cmts.send(UST_IE_REQDATA, 14'h3ff4, 14'h0018, 32'h0000_0c00, 1'b1);
      chk_tx(1'b1, UST_TX_CDATA, 2, 32'h0000_0c00);
      u_cmts.lose();
      chk("delivered", 32'h1, {31'h0, delivered});
      u_cmts.send(UST_IE_REQDATA, 14'h3ff4, 14'h0018, 32'h0000_0d00, 1'b1);
      chk("delivered off", 32'h0, {31'h0, delivered});
      chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      // a collision ack frees the flow for a fresh contention attempt
      want(2, 0, 1'b1);
      u_cmts.send(UST_IE_REQDATA, 14'h3ff4, 14'h0018, 32'h0000_0d40, 1'b0);
      chk_tx(1'b1, UST_TX_CDATA, 2, 32'h0000_0d40);
      acked(2, 1'b0);
      want(2, 1, 1'b1);
      u_cmts.send(UST_IE_REQDATA, 14'h3ff4, 14'h0018, 32'h0000_0d80, 1'b0);
      chk_tx(1'b1, UST_TX_CDATA, 2, 32'h0000_0d84);
      // a grant owns the flow for the rest of its map
      want(1, 0, 1'b0);
      u_cmts.send(UST_IE_LGRANT, flow[1].sid, 14'h0010, 32'h0000_0e00, 1'b1);
      chk_tx(1'b1, UST_TX_GRANT, 1, 32'h0000_0e00);
      want(1, 0, 1'b0);
      u_cmts.send(UST_IE_REQ, BC, 14'h0004, 32'h0000_0f00, 1'b0);
      chk_tx(1'b0, UST_TX_GRANT, 0, 0);
      // the next map frees the flow for contention again
      u_cmts.send(UST_IE_REQ, BC, 14'h0004, 32'h0000_1000, 1'b1);
      chk_tx(1'b1, UST_TX_CREQ, 1, 32'h0000_1000);
      end_of_test();
   end
endmodule
`default_nettype wire
